// file: inc/supply_switch_pkg.sv
// Register map, field layout, reset values and decode codes of the supply/switch/clock block
package supply_switch_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PIN_N = 4;

  // Register word offsets
  localparam logic [3:0] CLOCK_SELECT_ADDR = 4'h0;
  localparam logic [3:0] SUPPLY_MONITOR_PUMP_CONTROL_ADDR = 4'h1;
  localparam logic [3:0] ANALOG_SWITCH_CONTROL_ADDR = 4'h2;
  localparam logic [3:0] EVENT_STATUS_ADDR = 4'h3;
  localparam logic [3:0] EVENT_ENABLE_ADDR = 4'h4;
  localparam logic [3:0] EVENT_CLEAR_ADDR = 4'h5;

  // Clock select register fields
  localparam int OSC_ENABLE_BIT = 6;
  localparam int EXT_CFG_LSB = 4;
  localparam int ADC_DIV_LSB = 2;
  localparam int ACQ_LEN_LSB = 0;
  localparam logic [7:0] CLOCK_SELECT_MASK = 8'h7F;
  localparam logic [7:0] CLOCK_SELECT_RESET = 8'h61;

  // Supply monitor / pump control fields
  localparam int IRQ_POLARITY_BIT = 7;
  localparam int DIG_MON_LSB = 5;
  localparam int PUMP_MON_LSB = 2;
  localparam int PUMP_DIV_LSB = 0;
  localparam logic [7:0] SUPPLY_CONTROL_RESET = 8'h00;

  // Switch control fields
  localparam int DAC_FIRST_BIT = 7;
  localparam int DAC_SECOND_BIT = 6;
  localparam int OPAMP_FIRST_BIT = 5;
  localparam int OPAMP_SECOND_BIT = 4;
  localparam int THROW_FIRST_LSB = 2;
  localparam int THROW_SECOND_LSB = 0;
  localparam logic [7:0] SWITCH_MASK_DUAL_DAC = 8'hEF;
  localparam logic [7:0] SWITCH_MASK_DUAL_OPAMP = 8'hBF;
  localparam logic [7:0] SWITCH_CONTROL_RESET = 8'h00;

  // Event status bits
  localparam int EVT_DIG_LOW_BIT = 0;
  localparam int EVT_DIG_HIGH_BIT = 1;
  localparam int EVT_ANA_BIT = 2;
  localparam int EVT_N = 3;
  localparam logic [EVT_N-1:0] EVENT_RESET = 3'h0;

  // Analog supply threshold codes on ana_thresh_sel
  localparam logic [1:0] ANA_THRESH_2V7 = 2'h0;
  localparam logic [1:0] ANA_THRESH_3V8 = 2'h1;
  localparam logic [1:0] ANA_THRESH_4V5 = 2'h2;
  localparam logic [1:0] ANA_THRESH_3V6 = 2'h3;

  // Pump output voltage codes on pump_voltage_sel
  localparam logic [1:0] PUMP_OFF = 2'h0;
  localparam logic [1:0] PUMP_3V = 2'h1;
  localparam logic [1:0] PUMP_4V = 2'h2;
  localparam logic [1:0] PUMP_5V = 2'h3;

  // Pump / analog monitor field codes
  localparam logic [2:0] PM_ALL_OFF = 3'h0;
  localparam logic [2:0] PM_BYPASS = 3'h4;
endpackage : supply_switch_pkg

// file: rtl/supply_switch_clock_config.sv
// Supply monitor, charge-pump, clock divider and analog switch configuration block
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
module supply_switch_clock_config
  import supply_switch_pkg::*;
#(
  parameter bit DUAL_DAC = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic osc_clk_in,
  input wire logic ext_div_clk_in,
  input wire logic gain_high,
  input wire logic dig_below_low_in,
  input wire logic dig_below_high_in,
  input wire logic ana_below_in,
  input wire logic [PIN_N-1:0] prog_digital_pin,
  input wire logic [PIN_N-1:0] dac_first_pin_mask,
  input wire logic [PIN_N-1:0] dac_second_pin_mask,
  input wire logic [PIN_N-1:0] opamp_first_pin_mask,
  input wire logic [PIN_N-1:0] opamp_second_pin_mask,
  input wire logic [PIN_N-1:0] throw_first_pin_mask,
  input wire logic [PIN_N-1:0] throw_second_pin_mask,
  output logic adc_master_tick,
  output logic pump_clk_tick,
  output logic [5:0] acq_len_clocks,
  output logic supervisor_pin_a_out,
  output logic supervisor_pin_a_oe,
  output logic supervisor_pin_b_out,
  output logic supervisor_pin_b_oe,
  output logic dig_low_mon_en,
  output logic dig_high_mon_en,
  output logic pump_enable,
  output logic [1:0] pump_voltage_sel,
  output logic bypass_closed,
  output logic ana_supply_monitor,
  output logic [1:0] ana_thresh_sel,
  output logic dac_first_switch,
  output logic dac_second_switch,
  output logic opamp_first_switch,
  output logic opamp_second_switch,
  output logic double_throw_first_no,
  output logic double_throw_first_nc,
  output logic double_throw_second_no,
  output logic double_throw_second_nc,
  output logic irq
);

  localparam int SYNC_N = 9;
  localparam logic [DATA_W-1:0] SWITCH_MASK =
    DUAL_DAC ? SWITCH_MASK_DUAL_DAC : SWITCH_MASK_DUAL_OPAMP;

  function automatic logic any_assigned(input logic [PIN_N-1:0] mask,
                                        input logic [PIN_N-1:0] pins);
    any_assigned = |(mask & pins);
  endfunction : any_assigned

  // Returns {normally-open closed, normally-closed closed}
  function automatic logic [1:0] throw_state(input logic [1:0] field,
                                             input logic pin_or);
    logic drive;
    drive = field[0] | pin_or;
    if (field[1]) begin
      throw_state = {drive, ~drive};
    end else begin
      throw_state = {drive, drive};
    end
  endfunction : throw_state

  // Control registers
  logic [DATA_W-1:0] clock_select;
  logic [DATA_W-1:0] supply_monitor_pump_control;
  logic [DATA_W-1:0] analog_switch_control;
  logic [EVT_N-1:0] event_status;
  logic [EVT_N-1:0] event_enable;

  // Pin and clock synchronisers; stage one feeds stage two only
  logic [SYNC_N-1:0] sync_meta;
  logic [SYNC_N-1:0] sync_q;
  // Edge detectors reset to the idle low level, so no false tick follows reset
  logic [1:0] clk_prev;

  logic [2:0] adc_cnt;
  logic [7:0] pump_cnt;

  // Field views
  wire logic osc_enable = clock_select[OSC_ENABLE_BIT];
  wire logic [1:0] ext_clock_pin_cfg = clock_select[EXT_CFG_LSB +: 2];
  wire logic [1:0] adc_clk_div_sel = clock_select[ADC_DIV_LSB +: 2];
  wire logic [1:0] acq_len_sel = clock_select[ACQ_LEN_LSB +: 2];
  wire logic irq_polarity = supply_monitor_pump_control[IRQ_POLARITY_BIT];
  wire logic [1:0] dig_supply_monitor = supply_monitor_pump_control[DIG_MON_LSB +: 2];
  wire logic [2:0] pump_monitor_sel = supply_monitor_pump_control[PUMP_MON_LSB +: 3];
  wire logic [1:0] pump_clk_div_sel = supply_monitor_pump_control[PUMP_DIV_LSB +: 2];

  // Synchronised inputs
  wire logic [PIN_N-1:0] pins_s = sync_q[3:0];
  wire logic dig_low_below_s = sync_q[4];
  wire logic dig_high_below_s = sync_q[5];
  wire logic ana_below_s = sync_q[6];
  wire logic osc_s = sync_q[7];
  wire logic ext_s = sync_q[8];

  // Divider source selection
  wire logic osc_rise = osc_s & ~clk_prev[0];
  wire logic ext_rise = ext_s & ~clk_prev[1];
  // With the oscillator off and the pin as plain input there is no source at all
  wire logic src_tick = osc_enable ? osc_rise : ((ext_clock_pin_cfg != 2'h0) & ext_rise);

  wire logic [2:0] adc_limit = 3'(({3'h0, 1'b1} << adc_clk_div_sel) - 4'h1);
  wire logic [7:0] pump_limit = 8'((9'h020 << pump_clk_div_sel) - 9'h001);
  // Compare with >= so a divider shortened mid-count wraps at the next source edge
  wire logic adc_wrap = src_tick & (adc_cnt >= adc_limit);
  wire logic pump_wrap = src_tick & (pump_cnt >= pump_limit);
  wire logic [2:0] next_adc_cnt = adc_wrap ? 3'h0 : (src_tick ? adc_cnt + 3'h1 : adc_cnt);
  wire logic [7:0] next_pump_cnt = pump_wrap ? 8'h00 : (src_tick ? pump_cnt + 8'h01 : pump_cnt);

  // Acquisition length: base 2,4,8,16, doubled for gains 4 and 8
  // Shift amount is widened so code 3 at high gain reaches 32 instead of wrapping
  wire logic [5:0] next_acq_len = 6'(6'h02 << ({1'b0, acq_len_sel} + {2'h0, gain_high}));

  // Digital supply monitor roles
  wire logic pin_a_is_irq = dig_supply_monitor[1];
  wire logic pin_b_is_irq = dig_supply_monitor[0];
  wire logic next_low_mon_en = ~dig_supply_monitor[1];
  wire logic next_high_mon_en = ~dig_supply_monitor[0];

  // Pump / analog monitor decode
  logic next_pump_enable;
  logic [1:0] next_pump_voltage;
  logic next_bypass;
  logic next_ana_mon;
  logic [1:0] next_ana_thresh;

  always_comb begin
    next_pump_enable = 1'b0;
    next_pump_voltage = PUMP_OFF;
    next_bypass = 1'b0;
    next_ana_mon = 1'b0;
    next_ana_thresh = ANA_THRESH_2V7;
    unique case (pump_monitor_sel)
      PM_ALL_OFF: begin
      end
      3'h1: begin
        next_pump_enable = 1'b1;
        next_pump_voltage = PUMP_3V;
        next_ana_mon = 1'b1;
        next_ana_thresh = ANA_THRESH_2V7;
      end
      3'h2: begin
        next_pump_enable = 1'b1;
        next_pump_voltage = PUMP_4V;
        next_ana_mon = 1'b1;
        next_ana_thresh = ANA_THRESH_3V8;
      end
      3'h3: begin
        next_pump_enable = 1'b1;
        next_pump_voltage = PUMP_5V;
        next_ana_mon = 1'b1;
        next_ana_thresh = ANA_THRESH_4V5;
      end
      PM_BYPASS: begin
        next_bypass = 1'b1;
      end
      3'h5: begin
        next_ana_mon = 1'b1;
        next_ana_thresh = ANA_THRESH_2V7;
      end
      3'h6: begin
        next_ana_mon = 1'b1;
        next_ana_thresh = ANA_THRESH_3V6;
      end
      3'h7: begin
        next_ana_mon = 1'b1;
        next_ana_thresh = ANA_THRESH_4V5;
      end
    endcase
  end

  // Event flags: a set in the cycle of a clear still lands
  wire logic [EVT_N-1:0] event_set = {
    next_ana_mon & ana_below_s,
    next_high_mon_en & dig_high_below_s,
    next_low_mon_en & dig_low_below_s
  };
  wire logic clear_hit = reg_wr & (reg_addr == EVENT_CLEAR_ADDR);
  wire logic [EVT_N-1:0] event_clear = clear_hit ? reg_wdata[EVT_N-1:0] : EVENT_RESET;
  wire logic [EVT_N-1:0] next_event_status = event_set | (event_status & ~event_clear);
  // Built from the next status so irq rises on the same edge as the flag
  wire logic next_irq = |(next_event_status & event_enable);

  // Supervisor pins: monitor role pulls low while its supply is under threshold
  wire logic irq_pin_level = irq_polarity ? next_irq : ~next_irq;
  wire logic next_pin_a_out = pin_a_is_irq ? irq_pin_level : 1'b0;
  wire logic next_pin_a_oe = pin_a_is_irq | dig_low_below_s;
  wire logic next_pin_b_out = pin_b_is_irq ? irq_pin_level : 1'b0;
  wire logic next_pin_b_oe = pin_b_is_irq | dig_high_below_s;

  // Analog switches
  wire logic next_dac_first = analog_switch_control[DAC_FIRST_BIT]
    | any_assigned(dac_first_pin_mask, pins_s);
  wire logic next_dac_second = DUAL_DAC & (analog_switch_control[DAC_SECOND_BIT]
    | any_assigned(dac_second_pin_mask, pins_s));
  wire logic next_opamp_first = analog_switch_control[OPAMP_FIRST_BIT]
    | any_assigned(opamp_first_pin_mask, pins_s);
  wire logic next_opamp_second = ~DUAL_DAC & (analog_switch_control[OPAMP_SECOND_BIT]
    | any_assigned(opamp_second_pin_mask, pins_s));
  wire logic [1:0] next_throw_first = throw_state(
    analog_switch_control[THROW_FIRST_LSB +: 2],
    any_assigned(throw_first_pin_mask, pins_s));
  wire logic [1:0] next_throw_second = throw_state(
    analog_switch_control[THROW_SECOND_LSB +: 2],
    any_assigned(throw_second_pin_mask, pins_s));

  // Writes land at the strobe edge; derived outputs follow one edge later
  // Register bus decode
  wire logic wr_clock = reg_wr & (reg_addr == CLOCK_SELECT_ADDR);
  wire logic wr_supply = reg_wr & (reg_addr == SUPPLY_MONITOR_PUMP_CONTROL_ADDR);
  wire logic wr_switch = reg_wr & (reg_addr == ANALOG_SWITCH_CONTROL_ADDR);
  wire logic wr_enable = reg_wr & (reg_addr == EVENT_ENABLE_ADDR);
  logic [DATA_W-1:0] read_mux;

  // The clear register is write-only and reads as zero like unmapped words
  always_comb begin
    read_mux = 8'h00;
    unique case (reg_addr)
      CLOCK_SELECT_ADDR: read_mux = clock_select;
      SUPPLY_MONITOR_PUMP_CONTROL_ADDR: read_mux = supply_monitor_pump_control;
      ANALOG_SWITCH_CONTROL_ADDR: read_mux = analog_switch_control;
      EVENT_STATUS_ADDR: read_mux = {5'h00, event_status};
      EVENT_ENABLE_ADDR: read_mux = {5'h00, event_enable};
      default: read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_meta <= '0;
      sync_q <= '0;
      clk_prev <= 2'h0;
    end else begin
      sync_meta <= {ext_div_clk_in, osc_clk_in, ana_below_in, dig_below_high_in,
                    dig_below_low_in, prog_digital_pin};
      sync_q <= sync_meta;
      clk_prev <= {ext_s, osc_s};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clock_select <= CLOCK_SELECT_RESET;
      supply_monitor_pump_control <= SUPPLY_CONTROL_RESET;
      analog_switch_control <= SWITCH_CONTROL_RESET;
      event_enable <= EVENT_RESET;
    end else begin
      if (wr_clock) begin
        clock_select <= reg_wdata & CLOCK_SELECT_MASK;
      end
      if (wr_supply) begin
        supply_monitor_pump_control <= reg_wdata;
      end
      if (wr_switch) begin
        analog_switch_control <= reg_wdata & SWITCH_MASK;
      end
      if (wr_enable) begin
        event_enable <= reg_wdata[EVT_N-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      event_status <= EVENT_RESET;
      irq <= 1'b0;
    end else begin
      // Zero outside the answer cycle, so a stray sample of an idle bus reads clean
      reg_rdata <= reg_rd ? read_mux : 8'h00;
      event_status <= next_event_status;
      irq <= next_irq;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      adc_cnt <= 3'h0;
      pump_cnt <= 8'h00;
      adc_master_tick <= 1'b0;
      pump_clk_tick <= 1'b0;
      acq_len_clocks <= 6'h02;
    end else begin
      adc_cnt <= next_adc_cnt;
      pump_cnt <= next_pump_cnt;
      adc_master_tick <= adc_wrap;
      pump_clk_tick <= pump_wrap;
      acq_len_clocks <= next_acq_len;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      supervisor_pin_a_out <= 1'b0;
      supervisor_pin_a_oe <= 1'b0;
      supervisor_pin_b_out <= 1'b0;
      supervisor_pin_b_oe <= 1'b0;
      dig_low_mon_en <= 1'b0;
      dig_high_mon_en <= 1'b0;
      pump_enable <= 1'b0;
      pump_voltage_sel <= PUMP_OFF;
      bypass_closed <= 1'b0;
      ana_supply_monitor <= 1'b0;
      ana_thresh_sel <= ANA_THRESH_2V7;
    end else begin
      supervisor_pin_a_out <= next_pin_a_out;
      supervisor_pin_a_oe <= next_pin_a_oe;
      supervisor_pin_b_out <= next_pin_b_out;
      supervisor_pin_b_oe <= next_pin_b_oe;
      dig_low_mon_en <= next_low_mon_en;
      dig_high_mon_en <= next_high_mon_en;
      pump_enable <= next_pump_enable;
      pump_voltage_sel <= next_pump_voltage;
      bypass_closed <= next_bypass;
      ana_supply_monitor <= next_ana_mon;
      ana_thresh_sel <= next_ana_thresh;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dac_first_switch <= 1'b0;
      dac_second_switch <= 1'b0;
      opamp_first_switch <= 1'b0;
      opamp_second_switch <= 1'b0;
      double_throw_first_no <= 1'b0;
      double_throw_first_nc <= 1'b0;
      double_throw_second_no <= 1'b0;
      double_throw_second_nc <= 1'b0;
    end else begin
      dac_first_switch <= next_dac_first;
      dac_second_switch <= next_dac_second;
      opamp_first_switch <= next_opamp_first;
      opamp_second_switch <= next_opamp_second;
      double_throw_first_no <= next_throw_first[1];
      double_throw_first_nc <= next_throw_first[0];
      double_throw_second_no <= next_throw_second[1];
      double_throw_second_nc <= next_throw_second[0];
    end
  end

endmodule : supply_switch_clock_config

// file: testbench/supply_switch_assertions.sv
// Port-level assertions for the supply/switch/clock configuration block
`timescale 1ns/10ps
module supply_switch_assertions
  import supply_switch_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic gain_high,
  input wire logic pump_clk_tick,
  input wire logic [5:0] acq_len_clocks,
  input wire logic dig_low_mon_en,
  input wire logic pump_enable,
  input wire logic bypass_closed,
  input wire logic dac_first_switch,
  input wire logic double_throw_first_no,
  input wire logic double_throw_first_nc
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [7:0] clk_sel;
  logic [7:0] ctrl;
  logic [7:0] sw;
  // Shadow copies built from the bus; only the bits asserted on are trusted
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clk_sel <= CLOCK_SELECT_RESET;
      ctrl <= 8'h00;
      sw <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == CLOCK_SELECT_ADDR) clk_sel <= reg_wdata;
      if (reg_addr == SUPPLY_MONITOR_PUMP_CONTROL_ADDR) ctrl <= reg_wdata;
      if (reg_addr == ANALOG_SWITCH_CONTROL_ADDR) sw <= reg_wdata;
    end
  end
  sequence ctrl_read_s;
    reg_rd && reg_addr == SUPPLY_MONITOR_PUMP_CONTROL_ADDR;
  endsequence
  // Derived outputs lag the register by one flop, so skip the edge just out of reset
  sequence settled_s;
    !$past(rst);
  endsequence
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  ctrl_readback_a: assert property (ctrl_read_s |=> reg_rdata == $past(ctrl))
    else $error("control register read back wrong");
  dig_low_en_a: assert property (settled_s |-> dig_low_mon_en == !$past(ctrl[6]))
    else $error("low monitor enable wrong");
  pump_en_a: assert property (settled_s |->
    pump_enable == ($past(ctrl[4:2]) inside {3'h1, 3'h2, 3'h3}))
    else $error("pump enable wrong");
  bypass_a: assert property (settled_s |-> bypass_closed == ($past(ctrl[4:2]) == PM_BYPASS))
    else $error("bypass state wrong");
  dac_first_a: assert property (settled_s ##0 $past(sw[7]) |-> dac_first_switch)
    else $error("dac switch open with bit set");
  throw_pair_a: assert property (settled_s ##0 $past(sw[3]) |->
    double_throw_first_no != double_throw_first_nc)
    else $error("throws not complementary");
  throw_same_a: assert property (settled_s ##0 !$past(sw[3]) |->
    double_throw_first_no == double_throw_first_nc)
    else $error("throws differ");
  acq_len_a: assert property (settled_s |->
    acq_len_clocks == ((6'h2 << $past(clk_sel[1:0])) << $past(gain_high)))
    else $error("acquisition length wrong");
  pump_tick_a: assert property (pump_clk_tick |=> !pump_clk_tick [*8])
    else $error("pump ticks too close");
endmodule : supply_switch_assertions

// file: testbench/host_model.sv
// Host register bus master model
`timescale 1ns/10ps
module host_model
  import supply_switch_pkg::*;
(
  input wire logic sys_clk,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Idle lines show the inverse, so a slave sampling outside a strobe is caught
  task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge sys_clk);
    reg_addr <= ~a;
    reg_wdata <= ~d;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask : access
endmodule : host_model

// file: testbench/tb.sv
// Self-checking bench for the supply/switch/clock configuration block
`timescale 1ns/10ps
module tb;
  import supply_switch_pkg::*;
  logic sys_clk = 0, rst = 1, osc_clk_in = 0, ext_div_clk_in = 0, gain_high = 0;
  logic dig_below_low_in = 0, dig_below_high_in = 0, ana_below_in = 0;
  logic [3:0] prog_digital_pin = 0, dac_first_pin_mask = 0, dac_second_pin_mask = 0;
  logic [3:0] opamp_first_pin_mask = 0, opamp_second_pin_mask = 0;
  logic [3:0] throw_first_pin_mask = 0, throw_second_pin_mask = 0;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, adc_master_tick, pump_clk_tick, irq, bypass_closed, pump_enable;
  logic [5:0] acq_len_clocks;
  logic supervisor_pin_a_out, supervisor_pin_a_oe, supervisor_pin_b_out, supervisor_pin_b_oe;
  logic dig_low_mon_en, dig_high_mon_en, ana_supply_monitor, t1, t2, rd_seen = 0;
  logic [1:0] pump_voltage_sel, ana_thresh_sel;
  logic dac_first_switch, dac_second_switch, opamp_first_switch, opamp_second_switch;
  logic double_throw_first_no, double_throw_first_nc;
  logic double_throw_second_no, double_throw_second_nc;
  logic [7:0] q[$];
  logic [31:0] seed = 32'h05C581DD, r;
  int num_errors = 0, n_compared = 0, cyc = 0, n;
  localparam logic [1:0] TH [8] = '{2'h0, ANA_THRESH_2V7, ANA_THRESH_3V8, ANA_THRESH_4V5,
    2'h0, ANA_THRESH_2V7, ANA_THRESH_3V6, ANA_THRESH_4V5};
  supply_switch_clock_config dut_u (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .osc_clk_in, .ext_div_clk_in, .gain_high, .dig_below_low_in,
    .dig_below_high_in, .ana_below_in, .prog_digital_pin, .dac_first_pin_mask,
    .dac_second_pin_mask, .opamp_first_pin_mask, .opamp_second_pin_mask,
    .throw_first_pin_mask, .throw_second_pin_mask, .adc_master_tick, .pump_clk_tick,
    .acq_len_clocks, .supervisor_pin_a_out, .supervisor_pin_a_oe, .supervisor_pin_b_out,
    .supervisor_pin_b_oe, .dig_low_mon_en, .dig_high_mon_en, .pump_enable, .pump_voltage_sel,
    .bypass_closed, .ana_supply_monitor, .ana_thresh_sel, .dac_first_switch,
    .dac_second_switch, .opamp_first_switch, .opamp_second_switch, .double_throw_first_no,
    .double_throw_first_nc, .double_throw_second_no, .double_throw_second_nc, .irq);
  host_model host_u (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  always #12.5 sys_clk = ~sys_clk;
  // Free-running sources, 4 and 6 system cycles a period, never on a rising system edge
  always #50 osc_clk_in = ~osc_clk_in;
  always #75 ext_div_clk_in = ~ext_div_clk_in;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host_u.access(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    q.push_back(e);
    host_u.access(1'b0, a, 8'h00);
  endtask : rd
  task automatic w(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask : w
  // The first gap after a setting change may be partial, so only the last one counts
  task automatic gap(input bit p, input int exp);
    repeat (3) begin
      n = 0;
      do begin
        @(negedge sys_clk);
        n++;
      end while ((p ? pump_clk_tick : adc_master_tick) !== 1'b1 && n < 3000);
    end
    chk(16'(n), 16'(exp));
  endtask : gap
  always @(posedge sys_clk) rd_seen <= reg_rd;
  always @(negedge sys_clk) if (rd_seen) chk(reg_rdata, q.pop_front());
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd(CLOCK_SELECT_ADDR, CLOCK_SELECT_RESET);
    rd(SUPPLY_MONITOR_PUMP_CONTROL_ADDR, SUPPLY_CONTROL_RESET);
    rd(ANALOG_SWITCH_CONTROL_ADDR, SWITCH_CONTROL_RESET);
    rd(EVENT_ENABLE_ADDR, 8'h00);
    wr(EVENT_STATUS_ADDR, 8'hFF);
    rd(EVENT_STATUS_ADDR, 8'h00);
    rd(EVENT_CLEAR_ADDR, 8'h00);
    rd(4'h6, 8'h00);
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      wr(SUPPLY_MONITOR_PUMP_CONTROL_ADDR, r[7:0]);
      rd(SUPPLY_MONITOR_PUMP_CONTROL_ADDR, r[7:0]);
      wr(ANALOG_SWITCH_CONTROL_ADDR, r[15:8]);
      rd(ANALOG_SWITCH_CONTROL_ADDR, r[15:8] & SWITCH_MASK_DUAL_DAC);
      wr(CLOCK_SELECT_ADDR, r[23:16]);
      rd(CLOCK_SELECT_ADDR, r[23:16] & CLOCK_SELECT_MASK);
    end
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      wr(ANALOG_SWITCH_CONTROL_ADDR, r[7:0]);
      prog_digital_pin <= r[11:8];
      {dac_first_pin_mask, dac_second_pin_mask, opamp_first_pin_mask} <= r[23:12];
      {opamp_second_pin_mask, throw_first_pin_mask} <= r[31:24];
      throw_second_pin_mask <= r[15:12] ^ r[27:24];
      w(5);
      t1 = r[2] | |(prog_digital_pin & throw_first_pin_mask);
      t2 = r[0] | |(prog_digital_pin & throw_second_pin_mask);
      chk({dac_first_switch, dac_second_switch, opamp_first_switch, opamp_second_switch},
        {r[7] | |(prog_digital_pin & dac_first_pin_mask),
        r[6] | |(prog_digital_pin & dac_second_pin_mask),
        r[5] | |(prog_digital_pin & opamp_first_pin_mask), 1'b0});
      chk({double_throw_first_no, double_throw_first_nc, double_throw_second_no,
        double_throw_second_nc}, {t1, t1 ^ r[3], t2, t2 ^ r[1]});
    end
    for (int c = 0; c < 8; c++) begin
      wr(SUPPLY_MONITOR_PUMP_CONTROL_ADDR, 8'(c << 5));
      w(3);
      chk({dig_low_mon_en, dig_high_mon_en, supervisor_pin_a_oe, supervisor_pin_b_oe},
        {!c[1], !c[0], c[1], c[0]});
      chk({supervisor_pin_a_out & supervisor_pin_a_oe,
        supervisor_pin_b_out & supervisor_pin_b_oe}, {c[1] & !c[2], c[0] & !c[2]});
    end
    for (int c = 0; c < 8; c++) begin
      wr(SUPPLY_MONITOR_PUMP_CONTROL_ADDR, 8'(c << 2));
      w(3);
      chk({pump_enable, pump_voltage_sel, bypass_closed, ana_supply_monitor,
        ana_thresh_sel & {2{ana_supply_monitor}}},
        {c inside {1, 2, 3}, c < 4 ? 2'(c) : 2'h0, c == 4, c != 0 && c != 4, TH[c]});
    end
    wr(EVENT_ENABLE_ADDR, 8'h07);
    wr(SUPPLY_MONITOR_PUMP_CONTROL_ADDR, 8'h04);
    dig_below_low_in <= 1'b1;
    w(5);
    chk({irq, supervisor_pin_a_oe, supervisor_pin_a_out}, 3'b110);
    rd(EVENT_STATUS_ADDR, 8'h01);
    {dig_below_low_in, dig_below_high_in, ana_below_in} <= 3'b011;
    w(5);
    rd(EVENT_STATUS_ADDR, 8'h07);
    wr(EVENT_CLEAR_ADDR, 8'h07);
    rd(EVENT_STATUS_ADDR, 8'h06);
    wr(SUPPLY_MONITOR_PUMP_CONTROL_ADDR, 8'h60);
    wr(EVENT_CLEAR_ADDR, 8'h07);
    w(3);
    chk({irq, supervisor_pin_a_oe, supervisor_pin_a_out}, 3'b011);
    rd(EVENT_STATUS_ADDR, 8'h00);
    wr(SUPPLY_MONITOR_PUMP_CONTROL_ADDR, 8'h04);
    wr(EVENT_ENABLE_ADDR, 8'h00);
    w(4);
    chk(irq, 1'b0);
    rd(EVENT_STATUS_ADDR, 8'h06);
    wr(EVENT_ENABLE_ADDR, 8'h04);
    wr(SUPPLY_MONITOR_PUMP_CONTROL_ADDR, 8'hE0);
    rd(EVENT_ENABLE_ADDR, 8'h04);
    {dig_below_low_in, dig_below_high_in, ana_below_in} <= 3'b000;
    w(3);
    chk({irq, supervisor_pin_a_out, supervisor_pin_b_out, supervisor_pin_a_oe}, 4'hF);
    wr(EVENT_CLEAR_ADDR, 8'h07);
    w(3);
    chk({irq, supervisor_pin_a_out, supervisor_pin_b_oe}, 3'b001);
    for (int c = 0; c < 8; c++) begin
      wr(CLOCK_SELECT_ADDR, 8'(8'h40 | c[1:0]));
      gain_high <= c[2];
      w(3);
      chk(acq_len_clocks, 16'((2 << c[1:0]) << c[2]));
    end
    for (int d = 0; d < 4; d++) begin
      wr(SUPPLY_MONITOR_PUMP_CONTROL_ADDR, 8'(d));
      wr(CLOCK_SELECT_ADDR, 8'(8'h40 | d << 2));
      gap(1'b0, 4 << d);
      gap(1'b1, 128 << d);
      wr(CLOCK_SELECT_ADDR, 8'(8'h30 | d << 2));
      gap(1'b0, 6 << d);
      gap(1'b1, 192 << d);
    end
    wr(CLOCK_SELECT_ADDR, 8'h00);
    w(8);
    n = 0;
    repeat (600) begin
      @(negedge sys_clk);
      if (adc_master_tick !== 1'b0 || pump_clk_tick !== 1'b0) n++;
    end
    chk(16'(n), 16'h0000);
    tally_and_finish();
  end
endmodule : tb
bind supply_switch_clock_config supply_switch_assertions chk_u (.sys_clk, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .gain_high, .pump_clk_tick, .acq_len_clocks,
  .dig_low_mon_en, .pump_enable, .bypass_closed, .dac_first_switch, .double_throw_first_no,
  .double_throw_first_nc);
